//--- design/udc_counter.sv
// four-bit up/down counter with separate count inputs, zeroing and preset
`timescale 1ns/10ps

module udc_counter
  import udc_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  // count, load, zeroing and data pins, sampled
  input wire logic I_COUNT_UP,
  input wire logic I_COUNT_DOWN,
  input wire logic I_LOAD_N,
  input wire logic I_ASYNC_ZERO_INPUT,
  input wire logic [3:0] I_DATA,
  // results
  output logic [3:0] O_COUNT,
  output logic O_CARRY_N,
  output logic O_BORROW_N
);

  // ==========================================================
  // helpers
  localparam int unsigned CW = UDC_WIDTH;

  // count waits at the end of its range for the given direction
  function automatic logic at_range_end(
    input logic [CW-1:0] value,
    input logic going_up
  );
    logic result;
    if (going_up)
      result = (value == UDC_MAX);
    else
      result = (value == UDC_ZERO);
    return result;
  endfunction

  // own pin low, other pin parked high, no zeroing and no load
  function automatic logic pulse_qualified(
    input logic own_n,
    input logic other_n,
    input logic zero,
    input logic load_n
  );
    logic result;
    result = !own_n && other_n && !zero && load_n;
    return result;
  endfunction

  // ==========================================================
  // pin synchronisers
  udc_pins_s pins_raw;
  udc_pins_s meta_q;
  udc_pins_s pins_q;
  udc_pins_s pins_prev_q;

  // gather the pins into one word ahead of the first stage
  always_comb
  begin
    pins_raw = UDC_PINS_RESET;
    pins_raw.up_n = I_COUNT_UP;
    pins_raw.down_n = I_COUNT_DOWN;
    pins_raw.load_n = I_LOAD_N;
    pins_raw.zero = I_ASYNC_ZERO_INPUT;
    pins_raw.data = I_DATA;
  end

  // first stage, may go metastable; only the second stage reads it
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      meta_q <= UDC_PINS_RESET;
    end
    else
    begin
      meta_q <= pins_raw;
    end
  end

  // second stage, the first that logic may read
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      pins_q <= UDC_PINS_RESET;
    end
    else
    begin
      pins_q <= meta_q;
    end
  end

  // previous levels, reset to idle so no false edge follows reset
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      pins_prev_q <= UDC_PINS_RESET;
    end
    else
    begin
      pins_prev_q <= pins_q;
    end
  end

  // ==========================================================
  // edge detection
  logic up_rise;
  logic down_rise;

  // a rising edge only counts while the other count pin is parked high
  assign up_rise = pins_q.up_n && !pins_prev_q.up_n && pins_q.down_n;
  assign down_rise = pins_q.down_n && !pins_prev_q.down_n && pins_q.up_n;

  // ==========================================================
  // count register
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;

  // zeroing beats load, load beats up, up beats down
  always_comb
  begin
    count_d = count_q;
    if (pins_q.zero)
    begin
      count_d = UDC_ZERO;
    end
    else if (!pins_q.load_n)
    begin
      count_d = pins_q.data;
    end
    else if (up_rise)
    begin
      count_d = count_q + UDC_ONE;
    end
    else if (down_rise)
    begin
      count_d = count_q - UDC_ONE;
    end
  end

  // count state
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      count_q <= UDC_RESET_COUNT;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  // ==========================================================
  // carry and borrow, low while the wrapping count pulse is low
  logic carry_n_q;
  logic carry_n_d;
  logic borrow_n_q;
  logic borrow_n_d;

  // carry follows the up pulse while the count waits at fifteen
  always_comb
  begin
    carry_n_d = !(pulse_qualified(pins_q.up_n, pins_q.down_n, pins_q.zero, pins_q.load_n)
                  && at_range_end(count_q, 1'b1));
  end

  // borrow follows the down pulse while the count waits at zero
  always_comb
  begin
    borrow_n_d = !(pulse_qualified(pins_q.down_n, pins_q.up_n, pins_q.zero, pins_q.load_n)
                   && at_range_end(count_q, 1'b0));
  end

  // carry state, idle high
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      carry_n_q <= 1'b1;
    end
    else
    begin
      carry_n_q <= carry_n_d;
    end
  end

  // borrow state, idle high
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RESET)
    begin
      borrow_n_q <= 1'b1;
    end
    else
    begin
      borrow_n_q <= borrow_n_d;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  assign O_COUNT = count_q;
  assign O_CARRY_N = carry_n_q;
  assign O_BORROW_N = borrow_n_q;

endmodule

//--- design/udc_pkg.sv
// package for the single clock up/down counter
package udc_pkg;
  localparam int unsigned UDC_WIDTH = 4;
  localparam logic [3:0] UDC_ZERO = 4'h0;
  localparam logic [3:0] UDC_ONE = 4'h1;
  localparam logic [3:0] UDC_MAX = 4'hf;
  localparam logic [3:0] UDC_RESET_COUNT = 4'h0;
  // synchronised pin levels, idle high except the zeroing input and data, which idle low
  typedef struct packed {
    logic up_n;
    logic down_n;
    logic load_n;
    logic zero;
    logic [3:0] data;
  } udc_pins_s;
  localparam udc_pins_s UDC_PINS_RESET = '{up_n: 1'b1, down_n: 1'b1, load_n: 1'b1,
                                           zero: 1'b0, data: 4'h0};
endpackage

//--- dv/udc_driver.sv
// partner driving count pulses
`timescale 1ns/10ps
module udc_driver(input wire logic clk, output logic up, down);
  initial {up, down} = 2'b11;
  task automatic pulse(input bit u);
    repeat (4) @(posedge clk) {up, down} <= {!u, u};
    repeat (4) @(posedge clk) {up, down} <= 2'b11;
  endtask
endmodule

//--- dv/udc_checker.sv
// port assertions
`timescale 1ns/10ps
module udc_checker(input wire logic I_CORE_CLK, I_RESET, I_LOAD_N, I_ASYNC_ZERO_INPUT,
  input wire logic [3:0] I_DATA, O_COUNT, input wire logic O_CARRY_N, O_BORROW_N);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  a_zero_wins: assert property
    (I_ASYNC_ZERO_INPUT[*3] |=> O_COUNT == 4'h0) else $error("no zero");
  a_load_follows: assert property
    ((!I_LOAD_N && !I_ASYNC_ZERO_INPUT && $stable(I_DATA))[*3] |=> O_COUNT == I_DATA)
    else $error("no preset");
  a_zero_quiet: assert property
    (I_ASYNC_ZERO_INPUT[*3] |=> O_CARRY_N && O_BORROW_N) else $error("pulse under zero");
  a_carry_wrap: assert property ($fell(O_CARRY_N) |-> O_COUNT == 4'hf)
    else $error("carry");
  a_borrow_wrap: assert property ($fell(O_BORROW_N) |-> O_COUNT == 4'h0)
    else $error("borrow");
  a_one_step: assert property
    ($changed(O_COUNT) && $past(I_LOAD_N, 2) && !$past(I_ASYNC_ZERO_INPUT, 2)
    |-> O_COUNT == $past(O_COUNT) + 4'h1 || O_COUNT == $past(O_COUNT) - 4'h1)
    else $error("step");
endmodule
bind udc_counter udc_checker chk(.*);

//--- dv/udc_counter_bench.sv
// self-checking bench for the counter
`timescale 1ns/10ps
module udc_counter_bench;
  logic clk = 0, rst = 1, up, down, ld_n = 1, zero = 0, cy_n, bw_n, clr_flg = 1;
  logic [3:0] data = 4'hf, cnt, cy_len = 4'h0, bw_len = 4'h0;
  logic [1:0] flg = 2'h0;
  int num_errors, total_checks, cyc;
  udc_driver drv(.clk(clk), .up(up), .down(down));
  udc_counter uut(.I_CORE_CLK(clk), .I_RESET(rst), .I_COUNT_UP(up), .I_COUNT_DOWN(down),
    .I_LOAD_N(ld_n), .I_ASYNC_ZERO_INPUT(zero), .I_DATA(data), .O_COUNT(cnt),
    .O_CARRY_N(cy_n), .O_BORROW_N(bw_n));
  initial forever #12.5 clk = ~clk;
  // sticky pulse flags and pulse widths in clock cycles
  always @(posedge clk) flg <= clr_flg ? 2'h0 : flg | {~bw_n, ~cy_n};
  always @(posedge clk) cy_len <= clr_flg ? 4'h0 : cy_len + {3'h0, ~cy_n};
  always @(posedge clk) bw_len <= clr_flg ? 4'h0 : bw_len + {3'h0, ~bw_n};
  always @(posedge clk) if (++cyc > 3000) begin num_errors++; close_out(); end
  task automatic chk_count(input logic [3:0] a, e);
    total_checks++;
    if (a !== e) begin num_errors++; $display("unexpected %0t count %h", $time, a); end
  endtask
  task automatic chk_flags(input logic [3:0] a, e);
    total_checks++;
    if (a !== e) begin num_errors++; $display("unexpected %0t flags %h", $time, a); end
  endtask
  task automatic t_preset;
    @(posedge clk) {ld_n, clr_flg} <= 2'b00;
    drv.pulse(1);
    @(negedge clk) chk_count(cnt, 4'hf);
    @(posedge clk) zero <= 1;
    drv.pulse(0);
    @(negedge clk) chk_count(cnt, 4'h0);
    @(posedge clk) zero <= 0;
    repeat (4) @(posedge clk);
    @(negedge clk) chk_count(cnt, 4'hf);
    @(posedge clk) ld_n <= 1;
    repeat (4) @(posedge clk);
    @(negedge clk) chk_flags({2'h0, flg}, 4'h0);
    @(posedge clk) clr_flg <= 1;
    $display("preset done");
  endtask
  task automatic t_wrap;
    @(posedge clk) clr_flg <= 0;
    repeat (2) drv.pulse(1);
    @(negedge clk) chk_count(cnt, 4'h1);
    chk_flags({2'h0, flg}, 4'h1);
    chk_flags(cy_len, 4'h4);
    repeat (2) drv.pulse(0);
    @(negedge clk) chk_count(cnt, 4'hf);
    chk_flags({2'h0, flg}, 4'h3);
    chk_flags(bw_len, 4'h4);
    $display("wrap done");
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    t_preset();
    t_wrap();
    close_out();
  end
endmodule
